// [mau_top.sv]
// multiply accumulate unit: operand, command and result registers behind
// an avalon-mm slave, with a two-stage multiply then accumulate datapath.
// assumes one clock, an asynchronous active-low reset and a well-behaved
// avalon master that never raises read and write together.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "mau_defs.svh"
module mau_top
	import mau_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST
);

	logic [31:0] opa_r;
	logic [31:0] opb_r;
	logic [31:0] acc_lo_r;
	logic [31:0] acc_hi_r;
	logic [31:0] res_lo_r;
	logic [31:0] res_hi_r;
	logic [31:0] rdata_r;
	mau_cmd_t    cmd_r;
	mau_state_t  state_r;
	logic        sat_r;
	logic        badop_r;
	logic        wait_r;
	logic        grant;
	logic        busy;
	logic        wr_go;
	logic        rd_go;
	logic        launch;

	// word operand path, 33 bits so one multiplier serves both signednesses
	logic signed [32:0] wa;
	logic signed [32:0] wb;
	logic signed [65:0] wp_full;
	// halfword operand paths
	logic signed [16:0] ha0;
	logic signed [16:0] hb0;
	logic signed [16:0] ha1;
	logic signed [16:0] hb1;
	logic signed [33:0] hp0_full;
	logic signed [33:0] hp1_full;

	logic [15:0] n_lo;
	logic [15:0] n_hi;
	logic [15:0] m_lo;
	logic [15:0] m_hi;
	logic [15:0] m_pair_lo;
	logic [15:0] m_pair_hi;
	logic        sgn_word;
	mau_op_t     op;

	logic [63:0] wp;
	logic [31:0] hp0;
	logic [31:0] hp1;
	logic [63:0] top_sum;
	logic [31:0] top_word;
	logic [63:0] acc_pair;
	logic [32:0] dual_sum;
	logic        dual_ovf;
	logic [31:0] res_lo_nxt;
	logic [31:0] res_hi_nxt;
	logic        sat_set;
	logic        op_bad;

	assign busy            = (state_r != ST_IDLE);
	assign wr_go           = AVS_WRITE & ~wait_r;
	assign rd_go           = AVS_READ & grant;
	assign launch          = wr_go & (AVS_ADDRESS == `MAU_OFS_CMD)
				& AVS_BYTEENABLE[0];
	assign AVS_WAITREQUEST = wait_r;
	assign AVS_READDATA    = rdata_r;
	assign op              = mau_op_t'(cmd_r.op);

	mau_avs u_avs (
		.clk    (MCLK),
		.rst_n  (RESETN),
		.read   (AVS_READ),
		.write  (AVS_WRITE),
		.busy   (busy),
		.wait_r (wait_r),
		.grant  (grant)
	);

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
					      input logic [31:0] wd,
					      input logic [3:0]  be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// software-written operand and command registers
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			opa_r    <= `MAU_RST_WORD;
			opb_r    <= `MAU_RST_WORD;
			acc_lo_r <= `MAU_RST_WORD;
			acc_hi_r <= `MAU_RST_WORD;
		end else if (wr_go) begin
			case (AVS_ADDRESS)
			`MAU_OFS_OPA: begin
				opa_r <= merge(opa_r, AVS_WRITEDATA, AVS_BYTEENABLE);
			end
			`MAU_OFS_OPB: begin
				opb_r <= merge(opb_r, AVS_WRITEDATA, AVS_BYTEENABLE);
			end
			`MAU_OFS_ACCLO: begin
				acc_lo_r <= merge(acc_lo_r, AVS_WRITEDATA,
						  AVS_BYTEENABLE);
			end
			`MAU_OFS_ACCHI: begin
				acc_hi_r <= merge(acc_hi_r, AVS_WRITEDATA,
						  AVS_BYTEENABLE);
			end
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			cmd_r <= '0;
		end else if (launch) begin
			cmd_r <= mau_cmd_t'(AVS_WRITEDATA[7:0]);
		end
	end

	// ---------------------------------------------------------------
	// sequencer: launch, multiply stage, accumulate stage
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (launch) begin
					state_r <= ST_MUL;
				end
			end
			ST_MUL: begin
				state_r <= ST_ACC;
			end
			ST_ACC: begin
				state_r <= ST_IDLE;
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// operand selection
	// ---------------------------------------------------------------
	assign n_lo = opa_r[15:0];
	assign n_hi = opa_r[31:16];
	assign m_lo = opb_r[15:0];
	assign m_hi = opb_r[31:16];
	// exchange pairs bottom with top and top with bottom
	assign m_pair_lo = cmd_r.swp ? m_hi : m_lo;
	assign m_pair_hi = cmd_r.swp ? m_lo : m_hi;

	always_comb begin
		case (op)
		OP_U_LONG_MUL,
		OP_U_LONG_MAC,
		OP_U_LONG_DMAC: sgn_word = 1'b0;
		default:        sgn_word = 1'b1;
		endcase
	end

	always_comb begin
		wa  = {sgn_word & opa_r[31], opa_r};
		wb  = {sgn_word & opb_r[31], opb_r};
		ha0 = {n_lo[15], n_lo};
		hb0 = {m_pair_lo[15], m_pair_lo};
		ha1 = {n_hi[15], n_hi};
		hb1 = {m_pair_hi[15], m_pair_hi};
		case (op)
		OP_WORD_HALF_MUL: begin
			// selected halfword, sign-extended to the word path
			wb = cmd_r.m_top ? {{17{m_hi[15]}}, m_hi}
					 : {{17{m_lo[15]}}, m_lo};
		end
		OP_HALF_MUL: begin
			ha0 = cmd_r.n_top ? {n_hi[15], n_hi}
					  : {n_lo[15], n_lo};
			hb0 = cmd_r.m_top ? {m_hi[15], m_hi}
					  : {m_lo[15], m_lo};
		end
		default: begin
		end
		endcase
	end

	// full-precision products, registered at the end of the multiply stage
	mau_mul #(.W(33)) u_wmul (
		.clk   (MCLK),
		.rst_n (RESETN),
		.a     (wa),
		.b     (wb),
		.p     (wp_full)
	);

	mau_mul #(.W(17)) u_hmul0 (
		.clk   (MCLK),
		.rst_n (RESETN),
		.a     (ha0),
		.b     (hb0),
		.p     (hp0_full)
	);

	mau_mul #(.W(17)) u_hmul1 (
		.clk   (MCLK),
		.rst_n (RESETN),
		.a     (ha1),
		.b     (hb1),
		.p     (hp1_full)
	);

	// ---------------------------------------------------------------
	// accumulate stage
	// ---------------------------------------------------------------
	assign wp       = wp_full[63:0];
	assign hp0      = hp0_full[31:0];
	assign hp1      = hp1_full[31:0];
	assign acc_pair = {acc_hi_r, acc_lo_r};
	assign top_sum  = wp + (cmd_r.rnd ? `MAU_ROUND_K : 64'h0);
	assign top_word = top_sum[63:32];
	assign dual_sum = {hp0[31], hp0} + {hp1[31], hp1};
	assign dual_ovf = dual_sum[32] ^ dual_sum[31];

	always_comb begin
		res_lo_nxt = `MAU_RST_WORD;
		res_hi_nxt = `MAU_RST_WORD;
		sat_set    = 1'b0;
		op_bad     = 1'b0;
		case (op)
		OP_TOPW_MUL: begin
			res_lo_nxt = top_word;
		end
		OP_TOPW_MAC: begin
			res_lo_nxt = acc_lo_r + top_word;
		end
		OP_TOPW_MSUB: begin
			res_lo_nxt = acc_lo_r - top_word;
		end
		OP_DUAL_ADD: begin
			res_lo_nxt = dual_sum[31:0];
			sat_set    = dual_ovf;
		end
		OP_DUAL_SUB: begin
			res_lo_nxt = hp0 - hp1;
		end
		OP_HALF_MUL: begin
			res_lo_nxt = hp0;
		end
		OP_WORD_HALF_MUL: begin
			res_lo_nxt = wp[47:16];
		end
		OP_U_LONG_MUL,
		OP_S_LONG_MUL: begin
			{res_hi_nxt, res_lo_nxt} = wp;
		end
		OP_U_LONG_MAC: begin
			{res_hi_nxt, res_lo_nxt} = wp + acc_pair;
		end
		OP_S_LONG_MAC: begin
			{res_hi_nxt, res_lo_nxt} = wp + acc_pair;
		end
		OP_U_LONG_DMAC: begin
			// cannot exceed 64 bits: (2^32-1)^2 + 2(2^32-1) = 2^64-1
			{res_hi_nxt, res_lo_nxt} = wp + {32'h0, acc_hi_r}
						 + {32'h0, acc_lo_r};
		end
		default: begin
			op_bad = 1'b1;
		end
		endcase
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			res_lo_r <= `MAU_RST_WORD;
			res_hi_r <= `MAU_RST_WORD;
		end else if (state_r == ST_ACC) begin
			res_lo_r <= res_lo_nxt;
			res_hi_r <= res_hi_nxt;
		end
	end

	// ---------------------------------------------------------------
	// sticky status: only the dual add touches the saturation flag,
	// no other defined operation drives a flag, an undefined op sets badop_r; set wins over a clear
	// ---------------------------------------------------------------
	logic stat_wr;
	assign stat_wr = wr_go & (AVS_ADDRESS == `MAU_OFS_STAT)
		       & AVS_BYTEENABLE[0];

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			sat_r <= 1'b0;
		end else if ((state_r == ST_ACC) && sat_set) begin
			sat_r <= 1'b1;
		end else if (stat_wr && AVS_WRITEDATA[`MAU_ST_SAT]) begin
			sat_r <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			badop_r <= 1'b0;
		end else if ((state_r == ST_ACC) && op_bad) begin
			badop_r <= 1'b1;
		end else if (stat_wr && AVS_WRITEDATA[`MAU_ST_BADOP]) begin
			badop_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// read data, prepared in the grant cycle and held until the next
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_r <= `MAU_RST_WORD;
		end else if (rd_go) begin
			case (AVS_ADDRESS)
			`MAU_OFS_OPA:   rdata_r <= opa_r;
			`MAU_OFS_OPB:   rdata_r <= opb_r;
			`MAU_OFS_ACCLO: rdata_r <= acc_lo_r;
			`MAU_OFS_ACCHI: rdata_r <= acc_hi_r;
			`MAU_OFS_CMD:   rdata_r <= {24'h00_0000, cmd_r};
			`MAU_OFS_RESLO: rdata_r <= res_lo_r;
			`MAU_OFS_RESHI: rdata_r <= res_hi_r;
			`MAU_OFS_STAT: begin
				rdata_r                <= `MAU_RST_WORD;
				rdata_r[`MAU_ST_BUSY]  <= busy;
				rdata_r[`MAU_ST_SAT]   <= sat_r;
				rdata_r[`MAU_ST_BADOP] <= badop_r;
			end
			default:        rdata_r <= `MAU_RST_WORD;
			endcase
		end
	end

endmodule

// [mau_defs.svh]
// register map, field positions, reset values and constants of the
// multiply accumulate unit; included by every design file that needs them.
`ifndef MAU_DEFS_SVH
`define MAU_DEFS_SVH

// byte offsets of the word registers
`define MAU_OFS_OPA    5'h00
`define MAU_OFS_OPB    5'h04
`define MAU_OFS_ACCLO  5'h08
`define MAU_OFS_ACCHI  5'h0C
`define MAU_OFS_CMD    5'h10
`define MAU_OFS_RESLO  5'h14
`define MAU_OFS_RESHI  5'h18
`define MAU_OFS_STAT   5'h1C

// command register fields
`define MAU_CMD_OP_LSB 0
`define MAU_CMD_OP_MSB 3
`define MAU_CMD_RND    4
`define MAU_CMD_SWP    5
`define MAU_CMD_NTOP   6
`define MAU_CMD_MTOP   7

// status register fields
`define MAU_ST_BUSY    0
`define MAU_ST_SAT     1
`define MAU_ST_BADOP   2

`define MAU_RST_WORD   32'h0000_0000
`define MAU_ROUND_K    64'h0000_0000_8000_0000

`endif

// [mau_pkg.sv]
// types shared by the multiply accumulate unit files.
// assumes nothing beyond a SystemVerilog compiler.
package mau_pkg;

	typedef enum logic [3:0] {
		OP_TOPW_MUL,
		OP_TOPW_MAC,
		OP_TOPW_MSUB,
		OP_DUAL_ADD,
		OP_DUAL_SUB,
		OP_HALF_MUL,
		OP_WORD_HALF_MUL,
		OP_U_LONG_MUL,
		OP_U_LONG_MAC,
		OP_U_LONG_DMAC,
		OP_S_LONG_MUL,
		OP_S_LONG_MAC
	} mau_op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MUL,
		ST_ACC
	} mau_state_t;

	// members run from command bit 7 down to bit 0
	typedef struct packed {
		logic       m_top;
		logic       n_top;
		logic       swp;
		logic       rnd;
		logic [3:0] op;
	} mau_cmd_t;

endpackage

// [mau_mul.sv]
// registered signed multiplier, one stage of latency.
// assumes the caller extends operands to carry the wanted signedness.
`timescale 1ns/100ps
module mau_mul #(
	parameter int W = 17
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic signed [W-1:0]   a,
	input  wire logic signed [W-1:0]   b,
	output logic signed      [2*W-1:0] p
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p <= '0;
		end else begin
			p <= a * b;
		end
	end
endmodule

// [mau_avs.sv]
// avalon-mm slave handshake: one wait cycle per access, held off while busy.
// assumes a master that holds its request until waitrequest is seen low.
`timescale 1ns/100ps
module mau_avs (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic read,
	input  wire logic write,
	input  wire logic busy,
	output logic      wait_r,
	output logic      grant
);
	// grant marks the cycle in which the answer is prepared
	assign grant = (read | write) & wait_r & ~busy;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 1'b1;
		end else if (!wait_r) begin
			wait_r <= 1'b1;
		end else if (grant) begin
			wait_r <= 1'b0;
		end
	end
endmodule

// [mau_checker.sv]
// bus timing and two datapath results of the multiply accumulate unit.
// assumes it is bound to mau_top and sees only that module's ports.
`timescale 1ns/100ps
module mau_checker (
	input wire logic        MCLK,
	input wire logic        RESETN,
	input wire logic [4:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST
);
	logic [31:0] opa_r;
	logic [31:0] opb_r;
	logic [31:0] top_r;
	logic [31:0] half_r;
	logic [3:0]  op_r;
	logic        wdone;
	logic        rdone;

	assign wdone = AVS_WRITE && !AVS_WAITREQUEST;
	assign rdone = AVS_READ && !AVS_WAITREQUEST;

	function automatic logic [31:0] f_top(logic [31:0] a, logic [31:0] b,
		logic rnd);
		logic [63:0] p;
		p = $signed(a) * $signed(b);
		p = p + (rnd ? 64'h0000_0000_8000_0000 : 64'h0);
		return p[63:32];
	endfunction

	function automatic logic [31:0] f_half(logic [31:0] a, logic [31:0] b,
		logic n, logic m);
		logic [15:0] x;
		logic [15:0] y;
		x = n ? a[31:16] : a[15:0];
		y = m ? b[31:16] : b[15:0];
		return $signed(x) * $signed(y);
	endfunction

	// shadow operands, full-word writes only
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			opa_r <= 32'h0;
			opb_r <= 32'h0;
		end else if (wdone && AVS_BYTEENABLE == 4'hf) begin
			if (AVS_ADDRESS == 5'h00) opa_r <= AVS_WRITEDATA;
			if (AVS_ADDRESS == 5'h04) opb_r <= AVS_WRITEDATA;
		end
	end

	// expected results frozen when a command launches
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			op_r <= 4'hf;
			top_r <= 32'h0;
			half_r <= 32'h0;
		end else if (wdone && AVS_BYTEENABLE[0] && AVS_ADDRESS == 5'h10) begin
			op_r <= AVS_WRITEDATA[3:0];
			top_r <= f_top(opa_r, opb_r, AVS_WRITEDATA[4]);
			half_r <= f_half(opa_r, opb_r, AVS_WRITEDATA[6], AVS_WRITEDATA[7]);
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	property p_wait_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low for more than one cycle");
	property p_wait_cause;
		$fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE);
	endproperty
	a_wait_cause: assert property (p_wait_cause)
		else $error("waitrequest dropped without a request");
	property p_answer;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:6] !AVS_WAITREQUEST;
	endproperty
	a_answer: assert property (p_answer)
		else $error("request not answered in time");
	property p_cmd_stall;
		wdone && AVS_ADDRESS == 5'h10 && AVS_BYTEENABLE[0]
			|=> AVS_WAITREQUEST [*3];
	endproperty
	a_cmd_stall: assert property (p_cmd_stall)
		else $error("access granted while an operation runs");
	property p_unmapped;
		rdone && AVS_ADDRESS[1:0] != 2'b00 |-> AVS_READDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_rdata_hold;
		$changed(AVS_READDATA) |-> AVS_READ && $fell(AVS_WAITREQUEST);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed outside a read");
	property p_topw;
		rdone && AVS_ADDRESS == 5'h14 && op_r == 4'h0 |-> AVS_READDATA == top_r;
	endproperty
	a_topw: assert property (p_topw)
		else $error("top word product wrong");
	property p_half;
		rdone && AVS_ADDRESS == 5'h14 && op_r == 4'h5 |-> AVS_READDATA == half_r;
	endproperty
	a_half: assert property (p_half)
		else $error("halfword product wrong");

	c_cmd: cover property (wdone && AVS_ADDRESS == 5'h10);
	c_unmapped: cover property (rdone && AVS_ADDRESS == 5'h02);
	c_topw: cover property (rdone && AVS_ADDRESS == 5'h14 && op_r == 4'h0);
endmodule

bind mau_top mau_checker i_mau_checker (
	.MCLK(MCLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST)
);

// [mau_host.sv]
// bus master model standing in for the decoder and register file side.
// assumes the slave answers by lowering waitrequest for one cycle.
`timescale 1ns/100ps
module mau_host (
	input  wire logic        MCLK,
	input  wire logic [31:0] AVS_READDATA,
	input  wire logic        AVS_WAITREQUEST,
	output logic [4:0]       AVS_ADDRESS,
	output logic             AVS_READ,
	output logic             AVS_WRITE,
	output logic [31:0]      AVS_WRITEDATA,
	output logic [3:0]       AVS_BYTEENABLE,
	output logic             hung
);
	initial begin
		AVS_ADDRESS = 5'h0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'h0;
		hung = 1'b0;
	end

	// waits for the completing edge, gives up after 65 edges
	task automatic wait_ack();
		int n;
		n = 0;
		@(posedge MCLK);
		while (AVS_WAITREQUEST !== 1'b0 && n < 64) begin
			@(posedge MCLK);
			n++;
		end
		if (AVS_WAITREQUEST !== 1'b0)
			hung <= 1'b1;
	endtask

	// a released bus shows inverted address and write data; byte enables keep the old ones
	task automatic drop();
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		AVS_ADDRESS <= ~AVS_ADDRESS;
		AVS_WRITEDATA <= ~AVS_WRITEDATA;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		@(posedge MCLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		AVS_WRITE <= 1'b1;
		wait_ack();
		drop();
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge MCLK);
		AVS_ADDRESS <= a;
		AVS_READ <= 1'b1;
		wait_ack();
		d = AVS_READDATA;
		drop();
	endtask
endmodule

// [mau_top_tb.sv]
// self-checking bench: operation table, then flags, lanes and reset.
// assumes mau_host as bus master and mau_checker bound to mau_top.
`timescale 1ns/100ps
module mau_top_tb;
	typedef struct packed {
		logic [7:0]  c;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] lo;
		logic [31:0] hi;
		logic        sat;
	} mau_row_t;

	localparam logic [31:0] ka = 32'h8765_4321;
	localparam logic [31:0] kb = 32'h7edc_b234;
	localparam logic [31:0] kc = 32'h8000_8000;
	localparam logic [31:0] kd = 32'h0001_7fff;
	localparam logic [31:0] km = 32'h8000_0000;
	localparam logic [31:0] kx = 32'hffff_ffff;
	localparam logic [31:0] kz = 32'h0;

	// command byte, operands, accumulate pair, expected saturation
	mau_row_t rows [23] = '{
		'{8'h00, km, km, kz, kz, 1'b0},
		'{8'h10, ka, kb, kz, kz, 1'b0},
		'{8'h01, ka, kb, kd, kz, 1'b0},
		'{8'h11, kb, kb, ka, kz, 1'b0},
		'{8'h02, ka, kb, kd, kz, 1'b0},
		'{8'h03, ka, kb, kz, kz, 1'b0},
		'{8'h23, ka, kb, kz, kz, 1'b0},
		'{8'h03, kc, kc, kz, kz, 1'b1},
		'{8'h23, kc, kc, kz, kz, 1'b1},
		'{8'h04, ka, kb, kz, kz, 1'b0},
		'{8'h24, ka, kb, kz, kz, 1'b0},
		'{8'h05, ka, kb, kz, kz, 1'b0},
		'{8'h45, ka, kb, kz, kz, 1'b0},
		'{8'h85, ka, kb, kz, kz, 1'b0},
		'{8'hc5, ka, kb, kz, kz, 1'b0},
		'{8'h06, ka, kb, kz, kz, 1'b0},
		'{8'h86, ka, kb, kz, kz, 1'b0},
		'{8'h07, kx, kx, kz, kz, 1'b0},
		'{8'h08, ka, kb, kx, kx, 1'b0},
		'{8'h09, kx, kx, kx, kx, 1'b0},
		'{8'h0a, ka, kb, kz, kz, 1'b0},
		'{8'h0b, ka, kb, kd, kx, 1'b0},
		'{8'h0c, ka, kb, kz, kz, 1'b0}
	};

	logic        mclk = 1'b0;
	logic        resetn;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        hung;
	int          errors = 0;
	int          total_checks = 0;

	always #2 mclk = ~mclk;

	mau_top i_mau_top (
		.MCLK(mclk), .RESETN(resetn), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest)
	);

	mau_host i_mau_host (
		.MCLK(mclk), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.hung(hung)
	);

	task automatic test_done();
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] seen,
		input logic [63:0] want);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, want, seen);
		end
	endtask

	// returns saturation, high word and low word
	function automatic logic [64:0] ref_op(mau_row_t t);
		logic [63:0] p;
		logic [63:0] q;
		logic [63:0] r;
		logic [31:0] b2;
		logic [31:0] pb;
		logic [31:0] pt;
		logic [32:0] s;
		logic [15:0] hx;
		logic [15:0] hy;
		logic [47:0] pw;
		b2 = t.c[5] ? {t.b[15:0], t.b[31:16]} : t.b;
		pb = $signed(t.a[15:0]) * $signed(b2[15:0]);
		pt = $signed(t.a[31:16]) * $signed(b2[31:16]);
		s = {pb[31], pb} + {pt[31], pt};
		p = $signed(t.a) * $signed(t.b);
		q = p + (t.c[4] ? 64'h0000_0000_8000_0000 : 64'h0);
		hx = t.c[6] ? t.a[31:16] : t.a[15:0];
		hy = t.c[7] ? t.b[31:16] : t.b[15:0];
		pw = $signed(t.a) * $signed(hy);
		r = 64'h0;
		case (t.c[3:0])
		4'h0: r[31:0] = q[63:32];
		4'h1: r[31:0] = q[63:32] + t.lo;
		4'h2: r[31:0] = t.lo - q[63:32];
		4'h3: r[31:0] = s[31:0];
		4'h4: r[31:0] = pb - pt;
		4'h5: r[31:0] = $signed(hx) * $signed(hy);
		4'h6: r[31:0] = pw[47:16];
		4'h7: r = t.a * t.b;
		4'h8: r = t.a * t.b + {t.hi, t.lo};
		4'h9: r = t.a * t.b + t.hi + t.lo;
		4'ha: r = p;
		4'hb: r = p + {t.hi, t.lo};
		default: r = 64'h0;
		endcase
		return {t.c[3:0] == 4'h3 && s[32] != s[31], r};
	endfunction

	task automatic run(mau_row_t t);
		logic [64:0] e;
		logic [31:0] d;
		e = ref_op(t);
		i_mau_host.wr(5'h00, t.a);
		i_mau_host.wr(5'h04, t.b);
		i_mau_host.wr(5'h08, t.lo);
		i_mau_host.wr(5'h0c, t.hi);
		i_mau_host.wr(5'h10, {24'h0, t.c});
		i_mau_host.rd(5'h14, d);
		chk("result low", d, e[31:0]);
		i_mau_host.rd(5'h18, d);
		chk("result high", d, e[63:32]);
		i_mau_host.rd(5'h1c, d);
		chk("saturation", d[1], t.sat);
		i_mau_host.wr(5'h1c, 32'h6);
	endtask

	always @(posedge hung) begin
		errors++;
		test_done();
	end

	initial begin
		logic [31:0] d;
		resetn = 1'b0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		foreach (rows[i])
			run(rows[i]);
		// sticky saturation survives later top word and long operations
		i_mau_host.wr(5'h00, kc);
		i_mau_host.wr(5'h04, kc);
		i_mau_host.wr(5'h10, 32'h3);
		i_mau_host.wr(5'h10, 32'h0);
		i_mau_host.wr(5'h10, 32'hb);
		i_mau_host.rd(5'h1c, d);
		chk("sat kept", d, 32'h2);
		i_mau_host.wr(5'h1c, 32'h2);
		i_mau_host.wr(5'h10, 32'hc);
		i_mau_host.rd(5'h1c, d);
		chk("bad op", d, 32'h4);
		i_mau_host.rd(5'h10, d);
		chk("cmd back", d, 32'hc);
		// byte lanes merge, unmapped write has no effect
		i_mau_host.wr(5'h00, 32'h1111_1111);
		i_mau_host.wr(5'h00, 32'haaaa_bbbb, 4'h3);
		i_mau_host.wr(5'h01, 32'h0);
		i_mau_host.rd(5'h00, d);
		chk("lanes", d, 32'h1111_bbbb);
		// reset in mid-run clears every register
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("wait in reset", avs_waitrequest, 1'b1);
		chk("rdata in reset", avs_readdata, 32'h0);
		resetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			i_mau_host.rd(i < 8 ? 5'(i * 4) : 5'h02, d);
			chk("reset value", d, 32'h0);
		end
		test_done();
	end
endmodule
